// file: csbu_cond.sv
// Condition evaluation for skip and branch instructions.
`timescale 1ns/1ns
module csbu_cond import csbu_pkg::*; (
    // Instruction and state.
    input wire logic [3:0] op_in,
    input wire logic [2:0] sel_in,
    input wire logic [7:0] status_in,
    input wire logic [7:0] io_data_in,
    // Decision.
    output logic taken_out
);
    always_comb begin
        case (op_in)
            CSBU_OP_SKIP_IO: taken_out = io_data_in[sel_in]; // [RQ1]
            CSBU_OP_FLAG_SET: taken_out = status_in[sel_in]; // [RQ2]
            CSBU_OP_FLAG_CLR: taken_out = ~status_in[sel_in]; // [RQ3]
            CSBU_OP_EQ: taken_out = status_in[CSBU_FLAG_Z]; // [RQ4]
            CSBU_OP_NE: taken_out = ~status_in[CSBU_FLAG_Z]; // [RQ5]
            CSBU_OP_CS: taken_out = status_in[CSBU_FLAG_C]; // [RQ6]
            CSBU_OP_CC: taken_out = ~status_in[CSBU_FLAG_C]; // [RQ7]
            CSBU_OP_SH: taken_out = ~status_in[CSBU_FLAG_C]; // [RQ8]
            default: taken_out = 1'b0;
        endcase
    end
endmodule // csbu_cond

// file: csbu_pkg.sv
// Package of constants and types for the conditional skip and branch unit.
package csbu_pkg;
    localparam int CSBU_PC_W = 16;
    localparam int CSBU_K_W = 7;
    localparam logic [3:0] CSBU_OP_NONE = 4'h0;
    localparam logic [3:0] CSBU_OP_SKIP_IO = 4'h1;
    localparam logic [3:0] CSBU_OP_FLAG_SET = 4'h2;
    localparam logic [3:0] CSBU_OP_FLAG_CLR = 4'h3;
    localparam logic [3:0] CSBU_OP_EQ = 4'h4;
    localparam logic [3:0] CSBU_OP_NE = 4'h5;
    localparam logic [3:0] CSBU_OP_CS = 4'h6;
    localparam logic [3:0] CSBU_OP_CC = 4'h7;
    localparam logic [3:0] CSBU_OP_SH = 4'h8;
    localparam logic [2:0] CSBU_FLAG_C = 3'h0;
    localparam logic [2:0] CSBU_FLAG_Z = 3'h1;
    localparam logic [1:0] CSBU_CYC_ONE = 2'h1;
    localparam logic [1:0] CSBU_CYC_TWO = 2'h2;
    localparam logic [1:0] CSBU_CYC_THREE = 2'h3;
    localparam logic [15:0] CSBU_PC_RST = 16'h0000;
    localparam logic [7:0] CSBU_STATUS_REGISTER_RST = 8'h00;

    typedef struct packed {
        logic [3:0] op;
        logic [2:0] sel;
        logic [CSBU_K_W-1:0] k;
        logic [CSBU_PC_W-1:0] pc;
        logic next_two_words;
    } csbu_instr_t;

    typedef struct packed {
        logic [CSBU_PC_W-1:0] pc;
        logic [1:0] cycles;
        logic taken;
    } csbu_result_t;
endpackage

// file: csbu_unit.sv
// Conditional skip and branch execution unit with its own status register copy.
// How it works
// (RQ1) Skip tests the chosen I/O bit; when one, PC advances 2 or 3.
// (RQ2) Flag-set branch jumps to PC+k+1 when the chosen status bit is one.
// (RQ3) Flag-clear branch jumps to PC+k+1 when the chosen status bit is zero.
// (RQ4) Equal branch jumps to PC+k+1 when the zero flag is one.
// (RQ5) Not-equal branch jumps to PC+k+1 when the zero flag is zero.
// (RQ6) Carry-set branch jumps to PC+k+1 when carry is one.
// (RQ7) Carry-clear branch jumps to PC+k+1 when carry is zero.
// (RQ8) Same-or-higher branch jumps to PC+k+1 when carry is zero.
// (RQ9) None of these instructions changes any status flag.
// (RQ10) Skip over one word adds 2, over two words adds 3; cycles match.
// (RQ11) Offset k is signed; untaken branch costs 1 cycle, taken 2.
`timescale 1ns/1ns
module csbu_unit import csbu_pkg::*; (
    // Clock, reset and enable.
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // Instruction issue.
    input wire logic issue_in,
    input wire csbu_instr_t instr_in,
    input wire logic [7:0] io_data_in,
    // Status register load from the rest of the core.
    input wire logic status_wr_in,
    input wire logic [7:0] status_wdata_in,
    // Results.
    output logic done_out,
    output csbu_result_t result_out,
    output logic [7:0] status_out
);
    logic taken;
    logic [7:0] status_reg, status_next;
    logic done_reg, done_next;
    csbu_result_t result_reg, result_next;
    logic [CSBU_PC_W-1:0] k_ext;

    csbu_cond u_cond (
        .op_in(instr_in.op),
        .sel_in(instr_in.sel),
        .status_in(status_reg),
        .io_data_in(io_data_in),
        .taken_out(taken)
    );

    assign k_ext = {{(CSBU_PC_W-CSBU_K_W){instr_in.k[CSBU_K_W-1]}}, instr_in.k}; // [RQ11]

    always_comb begin
        status_next = status_reg;
        done_next = 1'b0;
        result_next = result_reg;
        if (status_wr_in) begin
            status_next = status_wdata_in;
        end
        if (issue_in && instr_in.op != CSBU_OP_NONE) begin
            done_next = 1'b1;
            result_next.taken = taken;
            if (instr_in.op == CSBU_OP_SKIP_IO) begin
                if (taken && instr_in.next_two_words) begin
                    result_next.pc = instr_in.pc + 16'h0003; // [RQ1] [RQ10]
                    result_next.cycles = CSBU_CYC_THREE;
                end else if (taken) begin
                    result_next.pc = instr_in.pc + 16'h0002; // [RQ1] [RQ10]
                    result_next.cycles = CSBU_CYC_TWO;
                end else begin
                    result_next.pc = instr_in.pc + 16'h0001;
                    result_next.cycles = CSBU_CYC_ONE;
                end
            end else if (taken) begin
                result_next.pc = instr_in.pc + k_ext + 16'h0001; // [RQ2] [RQ4] [RQ6] [RQ8]
                result_next.cycles = CSBU_CYC_TWO; // [RQ11]
            end else begin
                result_next.pc = instr_in.pc + 16'h0001; // [RQ3] [RQ5] [RQ7]
                result_next.cycles = CSBU_CYC_ONE; // [RQ11]
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            status_reg <= CSBU_STATUS_REGISTER_RST;
            done_reg <= 1'b0;
            result_reg <= '{pc: CSBU_PC_RST, cycles: 2'h0, taken: 1'b0};
        end else if (clk_en_in) begin
            status_reg <= status_next; // [RQ9]
            done_reg <= done_next;
            result_reg <= result_next;
        end
    end

    assign done_out = done_reg;
    assign result_out = result_reg;
    assign status_out = status_reg;

    // Reference target for a taken branch, with k sign-extended to the PC width.
    logic [CSBU_PC_W-1:0] branch_target;
    assign branch_target = instr_in.pc + {{(CSBU_PC_W-CSBU_K_W){instr_in.k[CSBU_K_W-1]}}, instr_in.k}
                           + 16'h0001;

    property p_flags_kept;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && !status_wr_in) |=> status_reg == $past(status_reg);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("Status changed by branch."); // [RQ9]

    property p_skip_pc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_SKIP_IO && io_data_in[instr_in.sel])
        |=> result_reg.pc == $past(instr_in.pc) + ($past(instr_in.next_two_words) ? 16'h0003 : 16'h0002);
    endproperty
    a_skip_pc: assert property (p_skip_pc) else $error("Skip PC wrong."); // [RQ1]

    property p_skip_cyc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_SKIP_IO)
        |=> result_reg.cycles == result_reg.pc - $past(instr_in.pc);
    endproperty
    a_skip_cyc: assert property (p_skip_cyc) else $error("Skip cycles wrong."); // [RQ10]

    property p_set;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_FLAG_SET)
        |=> result_reg.taken == $past(status_reg[instr_in.sel]);
    endproperty
    a_set: assert property (p_set) else $error("Flag set decision wrong."); // [RQ2]

    property p_clr;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_FLAG_CLR)
        |=> result_reg.taken != $past(status_reg[instr_in.sel]);
    endproperty
    a_clr: assert property (p_clr) else $error("Flag clear decision wrong."); // [RQ3]

    property p_eq;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_EQ && status_reg[CSBU_FLAG_Z])
        |=> result_reg.pc == $past(branch_target);
    endproperty
    a_eq: assert property (p_eq) else $error("Equal branch target wrong."); // [RQ4] [RQ11]

    property p_ne;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_NE)
        |=> result_reg.taken == !$past(status_reg[CSBU_FLAG_Z]);
    endproperty
    a_ne: assert property (p_ne) else $error("Not-equal decision wrong."); // [RQ5]

    property p_cs;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_CS)
        |=> result_reg.taken == $past(status_reg[CSBU_FLAG_C]);
    endproperty
    a_cs: assert property (p_cs) else $error("Carry set decision wrong."); // [RQ6]

    property p_cc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && (instr_in.op == CSBU_OP_CC || instr_in.op == CSBU_OP_SH))
        |=> result_reg.taken == !$past(status_reg[CSBU_FLAG_C]) && done_reg;
    endproperty
    a_cc: assert property (p_cc) else $error("Carry clear decision wrong."); // [RQ7] [RQ8]

    property p_br_cyc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (done_reg && result_reg.cycles == CSBU_CYC_ONE) |-> !result_reg.taken;
    endproperty
    a_br_cyc: assert property (p_br_cyc) else $error("Cycle count mismatch."); // [RQ11]

    property p_skip_none;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_SKIP_IO && !io_data_in[instr_in.sel])
        |=> result_reg.pc == $past(instr_in.pc) + 16'h0001 && result_reg.cycles == CSBU_CYC_ONE
            && !result_reg.taken;
    endproperty
    a_skip_none: assert property (p_skip_none) else $error("Skip not taken wrong."); // [RQ1] [RQ10]

    property p_set_pc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_FLAG_SET && status_reg[instr_in.sel])
        |=> result_reg.pc == $past(branch_target) && result_reg.cycles == CSBU_CYC_TWO;
    endproperty
    a_set_pc: assert property (p_set_pc) else $error("Flag set target wrong."); // [RQ2] [RQ11]

    property p_clr_pc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_FLAG_CLR && !status_reg[instr_in.sel])
        |=> result_reg.pc == $past(branch_target) && result_reg.cycles == CSBU_CYC_TWO;
    endproperty
    a_clr_pc: assert property (p_clr_pc) else $error("Flag clear target wrong."); // [RQ3] [RQ11]

    property p_ne_pc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_NE && !status_reg[CSBU_FLAG_Z])
        |=> result_reg.pc == $past(branch_target);
    endproperty
    a_ne_pc: assert property (p_ne_pc) else $error("Not-equal target wrong."); // [RQ5]

    property p_cs_pc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_CS && status_reg[CSBU_FLAG_C])
        |=> result_reg.pc == $past(branch_target);
    endproperty
    a_cs_pc: assert property (p_cs_pc) else $error("Carry set target wrong."); // [RQ6]

    property p_cs_untaken;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_CS && !status_reg[CSBU_FLAG_C])
        |=> result_reg.pc == $past(instr_in.pc) + 16'h0001 && result_reg.cycles == CSBU_CYC_ONE;
    endproperty
    a_cs_untaken: assert property (p_cs_untaken) else $error("Untaken branch wrong."); // [RQ6] [RQ11]

    property p_sh_pc;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && issue_in && instr_in.op == CSBU_OP_SH && !status_reg[CSBU_FLAG_C])
        |=> result_reg.pc == $past(branch_target) && result_reg.cycles == CSBU_CYC_TWO;
    endproperty
    a_sh_pc: assert property (p_sh_pc) else $error("Same-or-higher target wrong."); // [RQ8] [RQ11]

    property p_en_freeze;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        !clk_en_in
        |=> status_reg == $past(status_reg) && done_reg == $past(done_reg)
            && result_reg == $past(result_reg);
    endproperty
    a_en_freeze: assert property (p_en_freeze) else $error("State moved while disabled.");

    property p_done_pulse;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && !(issue_in && instr_in.op != CSBU_OP_NONE)) |=> !done_reg;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("Done without an issue.");

    property p_result_hold;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && !(issue_in && instr_in.op != CSBU_OP_NONE))
        |=> result_reg == $past(result_reg);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("Result changed without issue.");

    property p_status_load;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (clk_en_in && status_wr_in) |=> status_reg == $past(status_wdata_in);
    endproperty
    a_status_load: assert property (p_status_load) else $error("Status load lost.");

    c_skip3: cover property (@(posedge sys_clk_in) done_reg && result_reg.cycles == CSBU_CYC_THREE);
    c_taken: cover property (@(posedge sys_clk_in) done_reg && result_reg.taken);
    c_untaken: cover property (@(posedge sys_clk_in) done_reg && !result_reg.taken);
    c_skip2: cover property (@(posedge sys_clk_in) done_reg && result_reg.cycles == CSBU_CYC_TWO);
    c_frozen: cover property (@(posedge sys_clk_in) !clk_en_in && issue_in);
endmodule // csbu_unit

// file: csbu_unit_tb.sv
// Self-checking testbench for the conditional skip and branch unit.
`timescale 1ns/1ns
module csbu_unit_tb import csbu_pkg::*; ();
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic issue_in = 1'b0;
    logic status_wr_in = 1'b0;
    csbu_instr_t instr_in = '0;
    logic [7:0] io_data_in = 8'h00;
    logic [7:0] status_wdata_in = 8'h00;
    logic done_out;
    csbu_result_t result_out;
    logic [7:0] status_out;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    csbu_unit DUT (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .issue_in(issue_in),
        .instr_in(instr_in),
        .io_data_in(io_data_in),
        .status_wr_in(status_wr_in),
        .status_wdata_in(status_wdata_in),
        .done_out(done_out),
        .result_out(result_out),
        .status_out(status_out)
    );

    always #25 sys_clk_in = ~sys_clk_in;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results;
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            results();
        end
    end

    task automatic set_sr(input logic [7:0] v);
        @(negedge sys_clk_in);
        status_wr_in = 1'b1;
        status_wdata_in = v;
        @(negedge sys_clk_in);
        status_wr_in = 1'b0;
    endtask

    // Issues one instruction and compares the registered answer one cycle later.
    task automatic run(input logic [3:0] op, input logic [2:0] sel, input logic [6:0] k,
                       input logic [15:0] pc, input logic two, input logic [7:0] io,
                       input logic tk, input logic [15:0] epc, input logic [1:0] ecy);
        @(negedge sys_clk_in);
        issue_in = 1'b1;
        instr_in = '{op, sel, k, pc, two};
        io_data_in = io;
        @(negedge sys_clk_in);
        issue_in = 1'b0;
        chk("done", 16'h0001, {15'h0000, done_out});
        chk("taken", {15'h0000, tk}, {15'h0000, result_out.taken});
        chk("pc", epc, result_out.pc);
        chk("cycles", {14'h0000, ecy}, {14'h0000, result_out.cycles});
    endtask

    task automatic t_skip;
        run(CSBU_OP_SKIP_IO, 3'h3, 7'h00, 16'h0100, 1'b0, 8'h08, 1'b1, 16'h0102, CSBU_CYC_TWO);
        run(CSBU_OP_SKIP_IO, 3'h7, 7'h00, 16'h0200, 1'b1, 8'h80, 1'b1, 16'h0203, CSBU_CYC_THREE);
        run(CSBU_OP_SKIP_IO, 3'h3, 7'h00, 16'h0100, 1'b1, 8'hf7, 1'b0, 16'h0101, CSBU_CYC_ONE);
    endtask

    task automatic t_flag;
        logic [7:0] m;
        for (int s = 0; s < 8; s++) begin
            m = 8'h01 << s;
            set_sr(m);
            run(CSBU_OP_FLAG_SET, s[2:0], 7'h40, 16'h0010, 1'b0, 8'h00, 1'b1, 16'hffd1, CSBU_CYC_TWO);
            run(CSBU_OP_FLAG_CLR, s[2:0], 7'h3f, 16'h0010, 1'b0, 8'h00, 1'b0, 16'h0011, CSBU_CYC_ONE);
            set_sr(~m);
            run(CSBU_OP_FLAG_SET, s[2:0], 7'h3f, 16'h0010, 1'b0, 8'h00, 1'b0, 16'h0011, CSBU_CYC_ONE);
            run(CSBU_OP_FLAG_CLR, s[2:0], 7'h3f, 16'h0010, 1'b0, 8'h00, 1'b1, 16'h0050, CSBU_CYC_TWO);
            chk("status", {8'h00, ~m}, {8'h00, status_out});
        end
    endtask

    task automatic t_zc;
        logic [3:0] ops [5] = '{CSBU_OP_EQ, CSBU_OP_NE, CSBU_OP_CS, CSBU_OP_CC, CSBU_OP_SH};
        logic tk;
        for (int st = 0; st < 4; st++) begin
            set_sr(st[7:0]);
            for (int i = 0; i < 5; i++) begin
                case (i)
                    0: tk = st[1];
                    1: tk = !st[1];
                    2: tk = st[0];
                    default: tk = !st[0];
                endcase
                run(ops[i], 3'h0, 7'h7f, 16'h1234, 1'b0, 8'hff, tk, tk ? 16'h1234 : 16'h1235,
                    tk ? CSBU_CYC_TWO : CSBU_CYC_ONE);
            end
            chk("status", st[15:0], {8'h00, status_out});
        end
    endtask

    // The refused no-op opcode, an unused opcode run as an untaken branch, a frozen clock, a status load during issue and a reset in mid-run.
    task automatic t_hold;
        @(negedge sys_clk_in);
        issue_in = 1'b1;
        instr_in = '{CSBU_OP_NONE, 3'h0, 7'h01, 16'h0400, 1'b0};
        @(negedge sys_clk_in);
        issue_in = 1'b0;
        chk("none_done", 16'h0000, {15'h0000, done_out});
        chk("none_pc", 16'h1235, result_out.pc);
        run(4'h9, 3'h0, 7'h01, 16'h0400, 1'b0, 8'hff, 1'b0, 16'h0401, CSBU_CYC_ONE);
        @(negedge sys_clk_in);
        clk_en_in = 1'b0;
        issue_in = 1'b1;
        status_wr_in = 1'b1;
        status_wdata_in = 8'h00;
        instr_in = '{CSBU_OP_EQ, 3'h0, 7'h01, 16'h0500, 1'b0};
        @(negedge sys_clk_in);
        chk("frozen_done", 16'h0000, {15'h0000, done_out});
        chk("frozen_pc", 16'h0401, result_out.pc);
        chk("frozen_status", 16'h0003, {8'h00, status_out});
        clk_en_in = 1'b1;
        instr_in.op = CSBU_OP_NE;
        @(negedge sys_clk_in);
        issue_in = 1'b0;
        status_wr_in = 1'b0;
        chk("wr_done", 16'h0001, {15'h0000, done_out});
        chk("wr_taken", 16'h0000, {15'h0000, result_out.taken});
        chk("wr_pc", 16'h0501, result_out.pc);
        chk("wr_status", 16'h0000, {8'h00, status_out});
        @(negedge sys_clk_in);
        chk("done_pulse", 16'h0000, {15'h0000, done_out});
        arst_n_in = 1'b0;
        @(negedge sys_clk_in);
        chk("rst_done", 16'h0000, {15'h0000, done_out});
        chk("rst_pc", CSBU_PC_RST, result_out.pc);
        chk("rst_status", {8'h00, CSBU_STATUS_REGISTER_RST}, {8'h00, status_out});
        arst_n_in = 1'b1;
        run(CSBU_OP_CS, 3'h0, 7'h01, 16'h0700, 1'b0, 8'h00, 1'b0, 16'h0701, CSBU_CYC_ONE);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        arst_n_in = 1'b1;
        chk("status_rst", 16'h0000, {8'h00, status_out});
        t_skip();
        t_flag();
        t_zc();
        t_hold();
        results();
    end
endmodule // csbu_unit_tb
